// file: common/crt_regs_defines.vh
// Holds the port addresses, register indices and index reset value of the
// display timing register port.
// Assumes the includer compares them against a 16-bit I/O address.
`ifndef CRT_REGS_DEFINES_VH
`define CRT_REGS_DEFINES_VH

`define IDX_PORT_MONO        16'h03B4
`define DATA_PORT_MONO       16'h03B5
`define IDX_PORT_COLOUR      16'h03D4
`define DATA_PORT_COLOUR     16'h03D5
`define MISC_ADDR_SEL_BIT    0
`define INDEX_RESET          8'h00
`define IDX_HORIZONTAL_TOTAL 8'h00
`define IDX_HORIZONTAL_DISPLAY_END    8'h01
`define IDX_HORIZONTAL_BLANK_START    8'h02
`define IDX_HORIZONTAL_BLANK_END      8'h03
`define IDX_HORIZONTAL_SYNC_START     8'h04
`define IDX_HORIZONTAL_SYNC_END       8'h05
`define IDX_VERTICAL_TOTAL_LOW        8'h06
`define IDX_TIMING_OVERFLOW_BITS      8'h07
`define IDX_PRESET_ROW_SCAN           8'h08
`define IDX_MAXIMUM_SCAN_LINE         8'h09
`define IDX_TEXT_CURSOR_START_LINE    8'h0A
`define IDX_TEXT_CURSOR_END_LINE      8'h0B
`define IDX_START_ADDRESS_HIGH        8'h0C
`define IDX_START_ADDRESS_LOW         8'h0D
`define IDX_TEXT_CURSOR_LOCATION_HIGH 8'h0E
`define IDX_TEXT_CURSOR_LOCATION_LOW  8'h0F
`define IDX_VERTICAL_SYNC_START       8'h10
`define IDX_VERTICAL_SYNC_END         8'h11
`define IDX_VERTICAL_DISPLAY_END      8'h12
`define IDX_LINE_OFFSET               8'h13
`define IDX_UNDERLINE_ROW             8'h14
`define IDX_VERTICAL_BLANK_START      8'h15
`define IDX_VERTICAL_BLANK_END        8'h16
`define IDX_DISPLAY_MODE_CONTROL      8'h17
`define IDX_LINE_COMPARE              8'h18
`define IDX_EXT_VDE                   8'h31
`define IDX_EXT_VSS                   8'h32
`define IDX_INTERLACE_CONTROL         8'h70
`define IDX_TV_OUTPUT_CONTROL         8'h71
`define IDX_TV_SERRATION1_START       8'h72
`define IDX_TV_SERRATION2_START       8'h73
`define IDX_TV_PULSE_WIDTH            8'h74
`define IDX_TV_FILTER_BURST_LENGTH    8'h75
`define IDX_TV_FILTER_BURST_QUANTITY  8'h76
`define IDX_TV_FILTER_CONTROL         8'h77
`define IDX_LAST_BASIC       8'h18
`define IDX_MEM_READ_LATCHES 8'h22
`define IDX_EXT_VT           8'h30
`define IDX_EXT_VBS          8'h33
`define IDX_EXT_SA           8'h40
`define IDX_EXT_OFS          8'h41
`define IDX_TV_FIRST         8'h70
`define IDX_TV_LAST          8'h77
`define HTOTAL_EXTRA         8'h05
`define REG_SLOTS            39

`endif

// file: design/scan_line_timer.v
// Holds the horizontal character counter that spans one full scan line.
// Assumes a one-cycle character clock enable from the register file side.
`timescale 1ns/1ps
`include "crt_regs_defines.vh"

module scan_line_timer (
    // Clock and reset.
    input  wire       clock,
    input  wire       srst,
    // Timing control.
    input  wire       char_enable,
    input  wire [7:0] horizontal_total,
    // Scan position.
    output reg  [8:0] char_count,
    output reg        line_start
);

    // Period is the programmed value plus five, so zero still gives a line.
    wire [8:0] last_char;
    assign last_char = {1'b0, horizontal_total} + {1'b0, `HTOTAL_EXTRA} - 9'h001;

    always @(posedge clock) begin
        if (srst) begin
            char_count <= 9'h000;
            line_start <= 1'b0;
        end else begin
            line_start <= 1'b0;
            if (char_enable) begin
                if (char_count >= last_char) begin
                    char_count <= 9'h000;
                    line_start <= 1'b1;
                end else begin
                    char_count <= char_count + 9'h001;
                end
            end
        end
    end

endmodule

// file: design/crt_timing_register_port.v
// Holds the indexed display timing register file with its index and data
// ports, plus the scan-line counter that uses the horizontal total.
// Assumes one-cycle I/O read and write strobes synchronous to clock.
`timescale 1ns/1ps
`include "crt_regs_defines.vh"

module crt_timing_register_port #(
    parameter CHAR_DIVIDE = 8
) (
    // Clock and reset.
    input  wire        clock,
    input  wire        srst,
    // Host I/O access.
    input  wire [15:0] io_addr,
    input  wire        io_read,
    input  wire        io_write,
    input  wire [7:0]  io_wdata,
    output reg  [7:0]  io_rdata,
    output wire        io_hit,
    // Surrounding device state.
    input  wire [7:0]  misc_output_reg,
    input  wire [7:0]  memory_read_latches,
    // Timing outputs.
    output wire [7:0]  horizontal_total,
    output wire [8:0]  char_count,
    output wire        line_start
);

    ////////////////////////////////////////////////////////////////////////
    // Storage slots; listed indices are packed so no storage is wasted.
    localparam [5:0] SLOT_HORIZONTAL_TOTAL         = 6'h00;
    localparam [5:0] SLOT_HORIZONTAL_DISPLAY_END   = 6'h01;
    localparam [5:0] SLOT_HORIZONTAL_BLANK_START   = 6'h02;
    localparam [5:0] SLOT_HORIZONTAL_BLANK_END     = 6'h03;
    localparam [5:0] SLOT_HORIZONTAL_SYNC_START    = 6'h04;
    localparam [5:0] SLOT_HORIZONTAL_SYNC_END      = 6'h05;
    localparam [5:0] SLOT_VERTICAL_TOTAL_LOW       = 6'h06;
    localparam [5:0] SLOT_TIMING_OVERFLOW_BITS     = 6'h07;
    localparam [5:0] SLOT_PRESET_ROW_SCAN          = 6'h08;
    localparam [5:0] SLOT_MAXIMUM_SCAN_LINE        = 6'h09;
    localparam [5:0] SLOT_TEXT_CURSOR_START_LINE   = 6'h0A;
    localparam [5:0] SLOT_TEXT_CURSOR_END_LINE     = 6'h0B;
    localparam [5:0] SLOT_START_ADDRESS_HIGH       = 6'h0C;
    localparam [5:0] SLOT_START_ADDRESS_LOW        = 6'h0D;
    localparam [5:0] SLOT_TEXT_CURSOR_LOC_HIGH     = 6'h0E;
    localparam [5:0] SLOT_TEXT_CURSOR_LOC_LOW      = 6'h0F;
    localparam [5:0] SLOT_VERTICAL_SYNC_START      = 6'h10;
    localparam [5:0] SLOT_VERTICAL_SYNC_END        = 6'h11;
    localparam [5:0] SLOT_VERTICAL_DISPLAY_END     = 6'h12;
    localparam [5:0] SLOT_LINE_OFFSET              = 6'h13;
    localparam [5:0] SLOT_UNDERLINE_ROW            = 6'h14;
    localparam [5:0] SLOT_VERTICAL_BLANK_START     = 6'h15;
    localparam [5:0] SLOT_VERTICAL_BLANK_END       = 6'h16;
    localparam [5:0] SLOT_DISPLAY_MODE_CONTROL     = 6'h17;
    localparam [5:0] SLOT_LINE_COMPARE             = 6'h18;
    localparam [5:0] SLOT_EXT_VERTICAL_TOTAL       = 6'h19;
    localparam [5:0] SLOT_EXT_VERTICAL_DISPLAY_END = 6'h1A;
    localparam [5:0] SLOT_EXT_VERTICAL_SYNC_START  = 6'h1B;
    localparam [5:0] SLOT_EXT_VERTICAL_BLANK_START = 6'h1C;
    localparam [5:0] SLOT_EXT_START_ADDRESS        = 6'h1D;
    localparam [5:0] SLOT_EXT_LINE_OFFSET          = 6'h1E;
    localparam [5:0] SLOT_INTERLACE_CONTROL        = 6'h1F;
    localparam [5:0] SLOT_TV_OUTPUT_CONTROL        = 6'h20;
    localparam [5:0] SLOT_TV_SERRATION1_START      = 6'h21;
    localparam [5:0] SLOT_TV_SERRATION2_START      = 6'h22;
    localparam [5:0] SLOT_TV_PULSE_WIDTH           = 6'h23;
    localparam [5:0] SLOT_TV_FILTER_BURST_LENGTH   = 6'h24;
    localparam [5:0] SLOT_TV_FILTER_BURST_QUANTITY = 6'h25;
    localparam [5:0] SLOT_TV_FILTER_CONTROL        = 6'h26;
    localparam [5:0] NO_SLOT                       = 6'h3F;

    reg  [7:0] display_index_select;
    reg  [7:0] regs [0:`REG_SLOTS-1];
    reg  [7:0] next_rdata;
    reg  [7:0] div_count;
    reg        char_enable;
    wire       colour_range;
    wire       index_hit;
    wire       data_hit;
    wire [5:0] write_slot;
    integer    i;

    // Packs a listed index into its slot; the latch index and gaps get none.
    function [5:0] slot_of;
        input [7:0] idx;
        begin
            case (idx)
                `IDX_HORIZONTAL_TOTAL:
                    slot_of = SLOT_HORIZONTAL_TOTAL;
                `IDX_HORIZONTAL_DISPLAY_END:
                    slot_of = SLOT_HORIZONTAL_DISPLAY_END;
                `IDX_HORIZONTAL_BLANK_START:
                    slot_of = SLOT_HORIZONTAL_BLANK_START;
                `IDX_HORIZONTAL_BLANK_END:
                    slot_of = SLOT_HORIZONTAL_BLANK_END;
                `IDX_HORIZONTAL_SYNC_START:
                    slot_of = SLOT_HORIZONTAL_SYNC_START;
                `IDX_HORIZONTAL_SYNC_END:
                    slot_of = SLOT_HORIZONTAL_SYNC_END;
                `IDX_VERTICAL_TOTAL_LOW:
                    slot_of = SLOT_VERTICAL_TOTAL_LOW;
                `IDX_TIMING_OVERFLOW_BITS:
                    slot_of = SLOT_TIMING_OVERFLOW_BITS;
                `IDX_PRESET_ROW_SCAN:
                    slot_of = SLOT_PRESET_ROW_SCAN;
                `IDX_MAXIMUM_SCAN_LINE:
                    slot_of = SLOT_MAXIMUM_SCAN_LINE;
                `IDX_TEXT_CURSOR_START_LINE:
                    slot_of = SLOT_TEXT_CURSOR_START_LINE;
                `IDX_TEXT_CURSOR_END_LINE:
                    slot_of = SLOT_TEXT_CURSOR_END_LINE;
                `IDX_START_ADDRESS_HIGH:
                    slot_of = SLOT_START_ADDRESS_HIGH;
                `IDX_START_ADDRESS_LOW:
                    slot_of = SLOT_START_ADDRESS_LOW;
                `IDX_TEXT_CURSOR_LOCATION_HIGH:
                    slot_of = SLOT_TEXT_CURSOR_LOC_HIGH;
                `IDX_TEXT_CURSOR_LOCATION_LOW:
                    slot_of = SLOT_TEXT_CURSOR_LOC_LOW;
                `IDX_VERTICAL_SYNC_START:
                    slot_of = SLOT_VERTICAL_SYNC_START;
                `IDX_VERTICAL_SYNC_END:
                    slot_of = SLOT_VERTICAL_SYNC_END;
                `IDX_VERTICAL_DISPLAY_END:
                    slot_of = SLOT_VERTICAL_DISPLAY_END;
                `IDX_LINE_OFFSET:
                    slot_of = SLOT_LINE_OFFSET;
                `IDX_UNDERLINE_ROW:
                    slot_of = SLOT_UNDERLINE_ROW;
                `IDX_VERTICAL_BLANK_START:
                    slot_of = SLOT_VERTICAL_BLANK_START;
                `IDX_VERTICAL_BLANK_END:
                    slot_of = SLOT_VERTICAL_BLANK_END;
                `IDX_DISPLAY_MODE_CONTROL:
                    slot_of = SLOT_DISPLAY_MODE_CONTROL;
                `IDX_LINE_COMPARE:
                    slot_of = SLOT_LINE_COMPARE;
                `IDX_EXT_VT:
                    slot_of = SLOT_EXT_VERTICAL_TOTAL;
                `IDX_EXT_VDE:
                    slot_of = SLOT_EXT_VERTICAL_DISPLAY_END;
                `IDX_EXT_VSS:
                    slot_of = SLOT_EXT_VERTICAL_SYNC_START;
                `IDX_EXT_VBS:
                    slot_of = SLOT_EXT_VERTICAL_BLANK_START;
                `IDX_EXT_SA:
                    slot_of = SLOT_EXT_START_ADDRESS;
                `IDX_EXT_OFS:
                    slot_of = SLOT_EXT_LINE_OFFSET;
                `IDX_INTERLACE_CONTROL:
                    slot_of = SLOT_INTERLACE_CONTROL;
                `IDX_TV_OUTPUT_CONTROL:
                    slot_of = SLOT_TV_OUTPUT_CONTROL;
                `IDX_TV_SERRATION1_START:
                    slot_of = SLOT_TV_SERRATION1_START;
                `IDX_TV_SERRATION2_START:
                    slot_of = SLOT_TV_SERRATION2_START;
                `IDX_TV_PULSE_WIDTH:
                    slot_of = SLOT_TV_PULSE_WIDTH;
                `IDX_TV_FILTER_BURST_LENGTH:
                    slot_of = SLOT_TV_FILTER_BURST_LENGTH;
                `IDX_TV_FILTER_BURST_QUANTITY:
                    slot_of = SLOT_TV_FILTER_BURST_QUANTITY;
                `IDX_TV_FILTER_CONTROL:
                    slot_of = SLOT_TV_FILTER_CONTROL;
                default:
                    slot_of = NO_SLOT;
            endcase
        end
    endfunction

    // Listed writable indices; everything else has no storage behind it.
    function is_rw_index;
        input [7:0] idx;
        begin
            is_rw_index = (slot_of(idx) != NO_SLOT);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Ports move with the range bit; the other range simply does not decode.
    assign colour_range = misc_output_reg[`MISC_ADDR_SEL_BIT];
    assign index_hit = colour_range ? (io_addr == `IDX_PORT_COLOUR) :
                                      (io_addr == `IDX_PORT_MONO);
    assign data_hit  = colour_range ? (io_addr == `DATA_PORT_COLOUR) :
                                      (io_addr == `DATA_PORT_MONO);
    assign io_hit = (io_read | io_write) & (index_hit | data_hit);
    assign horizontal_total = regs[SLOT_HORIZONTAL_TOTAL];
    assign write_slot = slot_of(display_index_select);

    always @(posedge clock) begin
        if (srst) begin
            display_index_select <= `INDEX_RESET;
        end else if (io_write && index_hit) begin
            display_index_select <= io_wdata;
        end
    end

    // Timing register contents are left unreset; software programs a mode.
    always @(posedge clock) begin
        if (!srst && io_write && data_hit &&
            is_rw_index(display_index_select)) begin
            regs[write_slot] <= io_wdata;
        end
    end

    always @* begin
        next_rdata = 8'h00;
        if (index_hit) begin
            next_rdata = display_index_select;
        end else if (data_hit) begin
            case (display_index_select)
                `IDX_MEM_READ_LATCHES:
                    next_rdata = memory_read_latches;
                `IDX_HORIZONTAL_TOTAL:
                    next_rdata = regs[SLOT_HORIZONTAL_TOTAL];
                `IDX_HORIZONTAL_DISPLAY_END:
                    next_rdata = regs[SLOT_HORIZONTAL_DISPLAY_END];
                `IDX_HORIZONTAL_BLANK_START:
                    next_rdata = regs[SLOT_HORIZONTAL_BLANK_START];
                `IDX_HORIZONTAL_BLANK_END:
                    next_rdata = regs[SLOT_HORIZONTAL_BLANK_END];
                `IDX_HORIZONTAL_SYNC_START:
                    next_rdata = regs[SLOT_HORIZONTAL_SYNC_START];
                `IDX_HORIZONTAL_SYNC_END:
                    next_rdata = regs[SLOT_HORIZONTAL_SYNC_END];
                `IDX_VERTICAL_TOTAL_LOW:
                    next_rdata = regs[SLOT_VERTICAL_TOTAL_LOW];
                `IDX_TIMING_OVERFLOW_BITS:
                    next_rdata = regs[SLOT_TIMING_OVERFLOW_BITS];
                `IDX_PRESET_ROW_SCAN:
                    next_rdata = regs[SLOT_PRESET_ROW_SCAN];
                `IDX_MAXIMUM_SCAN_LINE:
                    next_rdata = regs[SLOT_MAXIMUM_SCAN_LINE];
                `IDX_TEXT_CURSOR_START_LINE:
                    next_rdata = regs[SLOT_TEXT_CURSOR_START_LINE];
                `IDX_TEXT_CURSOR_END_LINE:
                    next_rdata = regs[SLOT_TEXT_CURSOR_END_LINE];
                `IDX_START_ADDRESS_HIGH:
                    next_rdata = regs[SLOT_START_ADDRESS_HIGH];
                `IDX_START_ADDRESS_LOW:
                    next_rdata = regs[SLOT_START_ADDRESS_LOW];
                `IDX_TEXT_CURSOR_LOCATION_HIGH:
                    next_rdata = regs[SLOT_TEXT_CURSOR_LOC_HIGH];
                `IDX_TEXT_CURSOR_LOCATION_LOW:
                    next_rdata = regs[SLOT_TEXT_CURSOR_LOC_LOW];
                `IDX_VERTICAL_SYNC_START:
                    next_rdata = regs[SLOT_VERTICAL_SYNC_START];
                `IDX_VERTICAL_SYNC_END:
                    next_rdata = regs[SLOT_VERTICAL_SYNC_END];
                `IDX_VERTICAL_DISPLAY_END:
                    next_rdata = regs[SLOT_VERTICAL_DISPLAY_END];
                `IDX_LINE_OFFSET:
                    next_rdata = regs[SLOT_LINE_OFFSET];
                `IDX_UNDERLINE_ROW:
                    next_rdata = regs[SLOT_UNDERLINE_ROW];
                `IDX_VERTICAL_BLANK_START:
                    next_rdata = regs[SLOT_VERTICAL_BLANK_START];
                `IDX_VERTICAL_BLANK_END:
                    next_rdata = regs[SLOT_VERTICAL_BLANK_END];
                `IDX_DISPLAY_MODE_CONTROL:
                    next_rdata = regs[SLOT_DISPLAY_MODE_CONTROL];
                `IDX_LINE_COMPARE:
                    next_rdata = regs[SLOT_LINE_COMPARE];
                `IDX_EXT_VT:
                    next_rdata = regs[SLOT_EXT_VERTICAL_TOTAL];
                `IDX_EXT_VDE:
                    next_rdata = regs[SLOT_EXT_VERTICAL_DISPLAY_END];
                `IDX_EXT_VSS:
                    next_rdata = regs[SLOT_EXT_VERTICAL_SYNC_START];
                `IDX_EXT_VBS:
                    next_rdata = regs[SLOT_EXT_VERTICAL_BLANK_START];
                `IDX_EXT_SA:
                    next_rdata = regs[SLOT_EXT_START_ADDRESS];
                `IDX_EXT_OFS:
                    next_rdata = regs[SLOT_EXT_LINE_OFFSET];
                `IDX_INTERLACE_CONTROL:
                    next_rdata = regs[SLOT_INTERLACE_CONTROL];
                `IDX_TV_OUTPUT_CONTROL:
                    next_rdata = regs[SLOT_TV_OUTPUT_CONTROL];
                `IDX_TV_SERRATION1_START:
                    next_rdata = regs[SLOT_TV_SERRATION1_START];
                `IDX_TV_SERRATION2_START:
                    next_rdata = regs[SLOT_TV_SERRATION2_START];
                `IDX_TV_PULSE_WIDTH:
                    next_rdata = regs[SLOT_TV_PULSE_WIDTH];
                `IDX_TV_FILTER_BURST_LENGTH:
                    next_rdata = regs[SLOT_TV_FILTER_BURST_LENGTH];
                `IDX_TV_FILTER_BURST_QUANTITY:
                    next_rdata = regs[SLOT_TV_FILTER_BURST_QUANTITY];
                `IDX_TV_FILTER_CONTROL:
                    next_rdata = regs[SLOT_TV_FILTER_CONTROL];
                default:
                    next_rdata = 8'h00;
            endcase
        end
    end

    always @(posedge clock) begin
        if (srst) begin
            io_rdata <= 8'h00;
        end else if (io_read) begin
            io_rdata <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Character clock enable divided from the system clock.
    always @(posedge clock) begin
        if (srst) begin
            div_count   <= 8'h00;
            char_enable <= 1'b0;
        end else if (div_count == CHAR_DIVIDE[7:0] - 8'h01) begin
            div_count   <= 8'h00;
            char_enable <= 1'b1;
        end else begin
            div_count   <= div_count + 8'h01;
            char_enable <= 1'b0;
        end
    end

    scan_line_timer u_line (
        .clock            (clock),
        .srst             (srst),
        .char_enable      (char_enable),
        .horizontal_total (horizontal_total),
        .char_count       (char_count),
        .line_start       (line_start)
    );

    initial begin
        for (i = 0; i < `REG_SLOTS; i = i + 1) begin
            regs[i] = 8'h00;
        end
    end

endmodule

// file: bench/host_io.sv
// Host model issuing one-cycle I/O reads and writes.
// Assumes the bench shares its clock with the device.
`timescale 1ns/1ps
module host_io (input wire clock, input wire [7:0] io_rdata,
    output reg io_read = 1'b0, io_write = 1'b0,
    output reg [15:0] io_addr = 16'h0000, output reg [7:0] io_wdata = 8'h00);
    // Released lines flip so a stale address or byte cannot pass unseen.
    task xfer(input w, input [15:0] a, input [7:0] d, output [7:0] q);
        begin
            @(posedge clock);
            {io_write, io_read, io_addr, io_wdata} <= {w, !w, a, d};
            @(posedge clock);
            {io_write, io_read, io_addr, io_wdata} <= {2'b00, ~a, ~d};
            #1 q = io_rdata;
        end
    endtask
endmodule

// file: bench/crt_port_chk.sv
// Assertions on the timing register port.
// Assumes one clock with a synchronous active-high reset.
`timescale 1ns/1ps
module crt_port_chk (input wire clock, srst, io_read, io_write, io_hit,
    input wire [15:0] io_addr, input wire [7:0] io_wdata, io_rdata,
    input wire [7:0] misc_output_reg, memory_read_latches, horizontal_total);
    reg [7:0] idx_m;
    wire h = io_addr[15:1] == (misc_output_reg[0] ? 15'h1EA : 15'h1DA);
    wire rd = io_read && h && io_addr[0];
    wire wd = io_write && h && io_addr[0];
    always @(posedge clock)
        idx_m <= srst ? 8'h00 : io_write && h && !io_addr[0] ? io_wdata : idx_m;
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    property p_hit; io_read || io_write |-> io_hit == h; endproperty
    a_hit: assert property (p_hit) else $error("decode");
    property p_miss; io_read && !h |=> io_rdata == 8'h00; endproperty
    a_miss: assert property (p_miss) else $error("miss");
    property p_idx; io_read && h && !io_addr[0] |=> io_rdata == $past(idx_m);
    endproperty
    a_idx: assert property (p_idx) else $error("index");
    property p_ro; rd && idx_m == 8'h22 |=>
        io_rdata == $past(memory_read_latches); endproperty
    a_ro: assert property (p_ro) else $error("latch");
    property p_gap; rd && idx_m == 8'h19 |=> io_rdata == 8'h00; endproperty
    a_gap: assert property (p_gap) else $error("unlisted");
    property p_ht; wd && idx_m == 8'h00 |=>
        horizontal_total == $past(io_wdata); endproperty
    a_ht: assert property (p_ht) else $error("data");
    property p_rst; disable iff (1'b0) srst |=> io_rdata == 8'h00; endproperty
    a_rst: assert property (p_rst) else $error("reset");
    property p_hold; !io_read |=> $stable(io_rdata); endproperty
    a_hold: assert property (p_hold) else $error("hold");
endmodule
bind crt_timing_register_port crt_port_chk chk (.*);

// file: bench/tb_crt_timing_register_port.sv
// Bench for the timing register port: ranges, registers, line length.
// Assumes host_io makes every I/O cycle.
`timescale 1ns/1ps
module tb_crt_timing_register_port;
    localparam [63:0] LIST = 64'h0018304177221980;
    reg clock = 1'b0, srst = 1'b1;
    reg [7:0] misc_output_reg = 8'h00, memory_read_latches = 8'hC3, ix, q;
    wire io_read, io_write, io_hit, line_start;
    wire [15:0] io_addr;
    wire [7:0] io_wdata, io_rdata, horizontal_total;
    wire [8:0] char_count;
    integer n_mismatch = 0, check_count = 0, cyc = 0, i, g, s;
    host_io host (.*);
    crt_timing_register_port #(.CHAR_DIVIDE(1)) dut (.*);
    initial forever #20 clock = ~clock;
    task chk(input [31:0] nm, input [8:0] e, v);
        begin
            check_count = check_count + 1;
            if (v !== e) begin
                n_mismatch = n_mismatch + 1;
                $display("CHECK FAILED %s exp %h got %h", nm, e, v);
            end
        end
    endtask
    task give_verdict;
        begin
            $display("checks %0d mismatches %0d", check_count, n_mismatch);
            if (n_mismatch == 0 && check_count > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    task t_port;
        begin
            host.xfer(0, 16'h03B4, 8'h00, q);
            chk("idx", 8'h00, q);
            host.xfer(1, 16'h03B4, 8'hA5, q);
            host.xfer(1, 16'h03D4, 8'h11, q);
            host.xfer(0, 16'h03B4, 8'h00, q);
            chk("mono", 8'hA5, q);
            @(posedge clock);
            misc_output_reg <= 8'h01;
            host.xfer(0, 16'h03B4, 8'h00, q);
            chk("miss", 8'h00, q);
            host.xfer(0, 16'h03D4, 8'h00, q);
            chk("col", 8'hA5, q);
            $display("port test done");
        end
    endtask
    task t_regs;
        begin
            for (i = 0; i < 64; i = i + 8) begin
                ix = LIST[i +: 8];
                host.xfer(1, 16'h03D4, ix, q);
                host.xfer(1, 16'h03D5, ix ^ 8'h5A, q);
                host.xfer(0, 16'h03D5, 8'h00, q);
                ix = i < 16 ? 8'h00 : i == 16 ? 8'hC3 : ix ^ 8'h5A;
                chk("reg", ix, q);
            end
            $display("register test done");
        end
    endtask
    task t_line;
        begin
            host.xfer(1, 16'h03D4, 8'h00, q);
            host.xfer(1, 16'h03D5, 8'h0C - 8'h05, q);
            chk("ht", 8'h07, horizontal_total);
            g = 0;
            s = 0;
            for (i = 1; i < 700; i = i + 1) begin
                #40;
                if (line_start === 1'b1) begin
                    if (g > 0) chk("line", 9'h00C, 9'(i - g));
                    chk("cnt", 9'h000, char_count);
                    s = s + 1;
                    g = i;
                end
            end
            chk("runs", 9'h001, s > 2);
            $display("line test done");
        end
    endtask
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_mismatch = n_mismatch + 1;
            give_verdict;
        end
    end
    initial begin
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        t_port;
        t_regs;
        t_line;
        give_verdict;
    end
endmodule
